// [rtl/hspfc_params.svh]
/*
 * Constants of the host serial port: timing counts and buffer shape.
 * Assumes a 200 MHz system clock and 8N1 framing at a fixed bit rate.
 */
`ifndef HSPFC_PARAMS_SVH
`define HSPFC_PARAMS_SVH

`define HSPFC_CLK_HZ      200000000
`define HSPFC_BAUD_HZ     115200
// Clock cycles per bit, rounded down
`define HSPFC_BIT_CYCLES  (`HSPFC_CLK_HZ / `HSPFC_BAUD_HZ)
`define HSPFC_HALF_CYCLES (`HSPFC_BIT_CYCLES / 2)
`define HSPFC_CNT_W       16
`define HSPFC_DATA_W      8
`define HSPFC_FIFO_DEPTH  16
`define HSPFC_LAST_BIT    3'h7
`define HSPFC_LINE_IDLE   1'h1

`endif

// [rtl/hspfc_pkg.sv]
/*
 * Types shared by the host serial port modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package hspfc_pkg;

    // Gray-coded frame phases along idle, start, data, stop
    typedef enum logic [1:0] {
        HSPFC_IDLE  = 2'h0,
        HSPFC_START = 2'h1,
        HSPFC_DATA  = 2'h3,
        HSPFC_STOP  = 2'h2
    } hspfc_state_t;

endpackage : hspfc_pkg

// [rtl/hspfc_fifo.sv]
/*
 * Synchronous first-in first-out buffer with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
module hspfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Filling side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Draining side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_mem[wr_ptr] = in_data;
            next_wr_ptr      = wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        mem <= next_mem;
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

endmodule : hspfc_fifo

// [rtl/hspfc_top.sv]
/*
 * Host serial port with optional hardware flow control.
 * 8N1 transmitter fed from a 16-entry buffer, 8N1 receiver with one
 * holding register, clear-to-send and ready-to-send handshake pins.
 * Assumes a 200 MHz CLK, synchronous RST, and a host that obeys the
 * ready-to-send output while flow control is on.
 */
// Summary of operation
// - Send 8N1 character frames to the host on the transmit line.
// - Receive 8N1 character frames from the host on the receive line.
// - Clear-to-send matters only while flow control is enabled.
// - Host drives clear-to-send low to allow device transmission.
// - With flow control on and clear-to-send high, start no new frame.
// - Clear-to-send is looked at only when a frame would begin.
// - A frame already started always finishes before pausing.
// - Ready-to-send carries meaning only while flow control is enabled.
// - Ready-to-send low means the receiver can accept a character.
// - Ready-to-send high means the receiver is full; host holds off.
`include "hspfc_params.svh"

module hspfc_top (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RST,
    // Configuration
    input  wire logic                     FLOW_EN,
    // Transmit data from the device core
    input  wire logic [`HSPFC_DATA_W-1:0] TX_DATA,
    input  wire logic                     TX_VALID,
    output logic                          TX_READY,
    // Received data to the device core
    output logic      [`HSPFC_DATA_W-1:0] RX_DATA,
    output logic                          RX_VALID,
    input  wire logic                     RX_READY,
    output logic                          RX_OVERRUN,
    output logic                          RX_FRAME_ERR,
    // Host pins
    output logic                          HOST_TX_LINE,
    input  wire logic                     HOST_RX_LINE,
    input  wire logic                     HOST_CLEAR_TO_SEND_N,
    output logic                          HOST_READY_TO_SEND_N
);
    localparam logic [`HSPFC_CNT_W-1:0] BIT_LAST  = `HSPFC_CNT_W'(`HSPFC_BIT_CYCLES - 1);
    localparam logic [`HSPFC_CNT_W-1:0] HALF_LAST = `HSPFC_CNT_W'(`HSPFC_HALF_CYCLES - 1);

    // Pin synchronisers
    logic [1:0] rx_sync;
    logic [1:0] cts_sync;
    logic       rx_s;
    logic       cts_s;

    always_ff @(posedge CLK) begin
        if (RST) begin
            rx_sync  <= 2'h3;
            cts_sync <= 2'h3;
        end else begin
            rx_sync  <= {rx_sync[0], HOST_RX_LINE};
            cts_sync <= {cts_sync[0], HOST_CLEAR_TO_SEND_N};
        end
    end

    assign rx_s  = rx_sync[1];
    assign cts_s = cts_sync[1];

    // Transmit buffer
    logic [`HSPFC_DATA_W-1:0] fifo_data;
    logic                     fifo_valid;
    logic                     tx_take;

    hspfc_fifo #(
        .WIDTH (`HSPFC_DATA_W),
        .DEPTH (`HSPFC_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (CLK),
        .rst       (RST),
        .in_data   (TX_DATA),
        .in_valid  (TX_VALID),
        .in_ready  (TX_READY),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (tx_take)
    );

    // Transmitter
    hspfc_pkg::hspfc_state_t  tx_state;
    hspfc_pkg::hspfc_state_t  next_tx_state;
    logic [`HSPFC_CNT_W-1:0]  tx_cnt;
    logic [`HSPFC_CNT_W-1:0]  next_tx_cnt;
    logic [2:0]               tx_bit;
    logic [2:0]               next_tx_bit;
    logic [`HSPFC_DATA_W-1:0] tx_shift;
    logic [`HSPFC_DATA_W-1:0] next_tx_shift;
    logic                     tx_line;
    logic                     next_tx_line;
    logic                     tx_allowed;

    // Clear-to-send gates only the frame start, never a frame in flight
    assign tx_allowed = !FLOW_EN || !cts_s;
    assign tx_take    = (tx_state == hspfc_pkg::HSPFC_IDLE) && fifo_valid && tx_allowed;

    always_comb begin
        next_tx_state = tx_state;
        next_tx_cnt   = tx_cnt;
        next_tx_bit   = tx_bit;
        next_tx_shift = tx_shift;
        next_tx_line  = tx_line;
        if (tx_state != hspfc_pkg::HSPFC_IDLE && tx_cnt != '0) begin
            next_tx_cnt = tx_cnt - 1'b1;
        end
        case (tx_state)
            hspfc_pkg::HSPFC_IDLE: begin
                next_tx_line = `HSPFC_LINE_IDLE;
                if (tx_take) begin
                    next_tx_state = hspfc_pkg::HSPFC_START;
                    next_tx_shift = fifo_data;
                    next_tx_cnt   = BIT_LAST;
                    next_tx_line  = 1'b0;
                end
            end
            hspfc_pkg::HSPFC_START: begin
                if (tx_cnt == '0) begin
                    next_tx_state = hspfc_pkg::HSPFC_DATA;
                    next_tx_cnt   = BIT_LAST;
                    next_tx_bit   = '0;
                    next_tx_line  = tx_shift[0];
                    next_tx_shift = tx_shift >> 1;
                end
            end
            hspfc_pkg::HSPFC_DATA: begin
                if (tx_cnt == '0) begin
                    next_tx_cnt = BIT_LAST;
                    if (tx_bit == `HSPFC_LAST_BIT) begin
                        next_tx_state = hspfc_pkg::HSPFC_STOP;
                        next_tx_line  = `HSPFC_LINE_IDLE;
                    end else begin
                        next_tx_bit   = tx_bit + 1'b1;
                        next_tx_line  = tx_shift[0];
                        next_tx_shift = tx_shift >> 1;
                    end
                end
            end
            hspfc_pkg::HSPFC_STOP: begin
                if (tx_cnt == '0) begin
                    next_tx_state = hspfc_pkg::HSPFC_IDLE;
                end
            end
            default: begin
                next_tx_state = hspfc_pkg::HSPFC_IDLE;
                next_tx_line  = `HSPFC_LINE_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            tx_state <= hspfc_pkg::HSPFC_IDLE;
            tx_cnt   <= '0;
            tx_bit   <= '0;
            tx_shift <= '0;
            tx_line  <= `HSPFC_LINE_IDLE;
        end else begin
            tx_state <= next_tx_state;
            tx_cnt   <= next_tx_cnt;
            tx_bit   <= next_tx_bit;
            tx_shift <= next_tx_shift;
            tx_line  <= next_tx_line;
        end
    end

    assign HOST_TX_LINE = tx_line;

    // Receiver
    hspfc_pkg::hspfc_state_t  rx_state;
    hspfc_pkg::hspfc_state_t  next_rx_state;
    logic [`HSPFC_CNT_W-1:0]  rx_cnt;
    logic [`HSPFC_CNT_W-1:0]  next_rx_cnt;
    logic [2:0]               rx_bit;
    logic [2:0]               next_rx_bit;
    logic [`HSPFC_DATA_W-1:0] rx_shift;
    logic [`HSPFC_DATA_W-1:0] next_rx_shift;
    logic [`HSPFC_DATA_W-1:0] rx_hold;
    logic [`HSPFC_DATA_W-1:0] next_rx_hold;
    logic                     rx_full;
    logic                     next_rx_full;
    logic                     rx_ovr;
    logic                     next_rx_ovr;
    logic                     rx_ferr;
    logic                     next_rx_ferr;
    logic                     rts_n;
    logic                     next_rts_n;
    logic                     rx_store;

    always_comb begin
        next_rx_state = rx_state;
        next_rx_cnt   = rx_cnt;
        next_rx_bit   = rx_bit;
        next_rx_shift = rx_shift;
        next_rx_ferr  = 1'b0;
        rx_store      = 1'b0;
        if (rx_state != hspfc_pkg::HSPFC_IDLE && rx_cnt != '0) begin
            next_rx_cnt = rx_cnt - 1'b1;
        end
        case (rx_state)
            hspfc_pkg::HSPFC_IDLE: begin
                if (!rx_s) begin
                    next_rx_state = hspfc_pkg::HSPFC_START;
                    next_rx_cnt   = HALF_LAST;
                end
            end
            hspfc_pkg::HSPFC_START: begin
                // Mid-bit recheck rejects glitches shorter than half a bit
                if (rx_cnt == '0) begin
                    if (!rx_s) begin
                        next_rx_state = hspfc_pkg::HSPFC_DATA;
                        next_rx_cnt   = BIT_LAST;
                        next_rx_bit   = '0;
                    end else begin
                        next_rx_state = hspfc_pkg::HSPFC_IDLE;
                    end
                end
            end
            hspfc_pkg::HSPFC_DATA: begin
                if (rx_cnt == '0) begin
                    next_rx_shift = {rx_s, rx_shift[`HSPFC_DATA_W-1:1]};
                    next_rx_cnt   = BIT_LAST;
                    next_rx_bit   = rx_bit + 1'b1;
                    if (rx_bit == `HSPFC_LAST_BIT) begin
                        next_rx_state = hspfc_pkg::HSPFC_STOP;
                    end
                end
            end
            hspfc_pkg::HSPFC_STOP: begin
                if (rx_cnt == '0) begin
                    next_rx_state = hspfc_pkg::HSPFC_IDLE;
                    rx_store      = rx_s;
                    next_rx_ferr  = !rx_s;
                end
            end
            default: begin
                next_rx_state = hspfc_pkg::HSPFC_IDLE;
            end
        endcase
    end

    // Holding register; a new character wins over a same-cycle read
    always_comb begin
        next_rx_hold = rx_hold;
        next_rx_full = rx_full;
        next_rx_ovr  = 1'b0;
        if (RX_READY && rx_full) begin
            next_rx_full = 1'b0;
        end
        if (rx_store) begin
            next_rx_hold = rx_shift;
            next_rx_full = 1'b1;
            next_rx_ovr  = rx_full && !RX_READY;
        end
        if (!FLOW_EN) begin
            next_rts_n = 1'b0;
        end else begin
            next_rts_n = next_rx_full;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rx_state <= hspfc_pkg::HSPFC_IDLE;
            rx_cnt   <= '0;
            rx_bit   <= '0;
            rx_shift <= '0;
            rx_hold  <= '0;
            rx_full  <= 1'b0;
            rx_ovr   <= 1'b0;
            rx_ferr  <= 1'b0;
            rts_n    <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            rx_cnt   <= next_rx_cnt;
            rx_bit   <= next_rx_bit;
            rx_shift <= next_rx_shift;
            rx_hold  <= next_rx_hold;
            rx_full  <= next_rx_full;
            rx_ovr   <= next_rx_ovr;
            rx_ferr  <= next_rx_ferr;
            rts_n    <= next_rts_n;
        end
    end

    assign RX_DATA              = rx_hold;
    assign RX_VALID             = rx_full;
    assign RX_OVERRUN           = rx_ovr;
    assign RX_FRAME_ERR         = rx_ferr;
    assign HOST_READY_TO_SEND_N = rts_n;

endmodule : hspfc_top

// [dv/hspfc_monitor.sv]
/*
 * Checker for the host serial port: frame shape, flow-control pins, receive holding.
 * Assumes it is bound to hspfc_top, one clock, synchronous active-high reset.
 */
`include "hspfc_params.svh"

module hspfc_monitor (
    // Clock and reset
    input wire logic                     CLK,
    input wire logic                     RST,
    // Core side
    input wire logic                     FLOW_EN,
    input wire logic                     TX_READY,
    input wire logic [`HSPFC_DATA_W-1:0] RX_DATA,
    input wire logic                     RX_VALID,
    input wire logic                     RX_READY,
    input wire logic                     RX_OVERRUN,
    // Host pins
    input wire logic                     HOST_TX_LINE,
    input wire logic                     HOST_CLEAR_TO_SEND_N,
    input wire logic                     HOST_READY_TO_SEND_N
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = `HSPFC_BIT_CYCLES;
    localparam int FRAME = 10 * BIT;

    // Frame position, counting down from the start-bit edge
    logic        line_q;
    logic        next_line_q;
    logic [15:0] fcnt;
    logic [15:0] next_fcnt;
    logic        start;

    always_comb begin
        start = (fcnt == 16'h0000) && line_q && !HOST_TX_LINE;
        next_line_q = HOST_TX_LINE;
        next_fcnt = fcnt;
        if (start) begin
            next_fcnt = 16'(FRAME - 1);
        end else if (fcnt != 16'h0000) begin
            next_fcnt = fcnt - 16'h0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            line_q <= 1'h1;
            fcnt <= 16'h0000;
        end else begin
            line_q <= next_line_q;
            fcnt <= next_fcnt;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    AST_RESET_STATE: assert property ($past(RST) |->
        HOST_TX_LINE && TX_READY && !RX_VALID && !HOST_READY_TO_SEND_N) else $error("outputs not idle after reset");
    AST_START_LOW: assert property (fcnt > 16'(9 * BIT) |-> !HOST_TX_LINE)
        else $error("start bit not held low");
    AST_STOP_HIGH: assert property (fcnt != 16'h0000 && fcnt <= 16'(BIT) |-> HOST_TX_LINE)
        else $error("stop bit not high");
    AST_BIT_STABLE: assert property (fcnt != 16'h0000 && (int'(fcnt) % BIT) != 0 |-> $stable(HOST_TX_LINE))
        else $error("line changed inside a bit");
    AST_NO_START_BLOCKED: assert property ((FLOW_EN && HOST_CLEAR_TO_SEND_N) [*5] |-> !start)
        else $error("frame began while clear-to-send high");
    AST_RTS_OFF: assert property (!FLOW_EN ##1 !FLOW_EN |-> !HOST_READY_TO_SEND_N)
        else $error("ready-to-send high without flow control");
    AST_RTS_FULL: assert property (FLOW_EN ##1 FLOW_EN |-> HOST_READY_TO_SEND_N == RX_VALID)
        else $error("ready-to-send does not follow holding state");
    AST_RX_HOLD: assert property (RX_VALID && !RX_READY ##1 !RX_OVERRUN |-> RX_VALID && $stable(RX_DATA))
        else $error("received byte lost before read");
endmodule : hspfc_monitor

bind hspfc_top hspfc_monitor i_mon (
    .CLK(CLK), .RST(RST), .FLOW_EN(FLOW_EN), .TX_READY(TX_READY), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
    .RX_READY(RX_READY), .RX_OVERRUN(RX_OVERRUN), .HOST_TX_LINE(HOST_TX_LINE),
    .HOST_CLEAR_TO_SEND_N(HOST_CLEAR_TO_SEND_N), .HOST_READY_TO_SEND_N(HOST_READY_TO_SEND_N)
);

// [dv/hspfc_host_model.sv]
/*
 * Host processor model: decodes 8N1 frames from the device, sends 8N1 frames to it.
 * Assumes the device bit time and a clock shared with the device.
 */
`include "hspfc_params.svh"

module hspfc_host_model (
    // Clock
    input wire logic clk,
    // Device pins
    input wire logic dev_tx_line,
    input wire logic dev_rts_n,
    output logic     host_rx_line,
    output logic     host_cts_n,
    // Test control
    input wire logic flow_en,
    input wire logic cts_n_req
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = `HSPFC_BIT_CYCLES;
    logic [7:0] got[$];

    assign host_cts_n = cts_n_req;
    initial host_rx_line = 1'h1;

    // Shifts a whole frame, stop bit included, without looking at ready-to-send
    task automatic send_raw(input logic [9:0] f);
        for (int i = 0; i < 10; i++) begin
            host_rx_line <= f[i];
            repeat (BIT) @(posedge clk);
        end
    endtask : send_raw

    task automatic send(input logic [7:0] b);
        while (flow_en && dev_rts_n) @(posedge clk);
        send_raw({1'h1, b, 1'h0});
    endtask : send

    // Samples mid-bit; a byte with a bad stop bit is dropped
    always begin : watch
        logic [7:0] b;
        @(negedge dev_tx_line);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            b[i] = dev_tx_line;
        end
        repeat (BIT) @(posedge clk);
        if (dev_tx_line === 1'h1) got.push_back(b);
    end
endmodule : hspfc_host_model

// [dv/tb_host_serial_port_flow_control.sv]
/*
 * Testbench of the host serial port: table of flow-control cases, then fill, pause, receive-error and reset tests.
 * Assumes the host model and the bound checker.
 */
`include "hspfc_params.svh"

module tb_host_serial_port_flow_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = `HSPFC_BIT_CYCLES;
    typedef struct packed {
        logic       flow;
        logic       cts_n;
        logic [7:0] tx;
        logic       sent;
        logic [7:0] rx;
    } hspfc_row_t;

    logic       clk = 1'h0, rst = 1'h1, flow_en = 1'h0, tx_valid = 1'h0, rx_ready = 1'h0, cts_n = 1'h0;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] rx_data;
    logic       tx_ready, rx_valid, rx_overrun, rx_frame_err, tx_line, rx_line, rts_n, cts_pin;
    int         mismatches = 0;
    int         check_count = 0;
    int         ferr_seen = 0;
    int         ovr_seen = 0;
    hspfc_row_t rows [3] = '{'{1'h0, 1'h1, 8'ha5, 1'h1, 8'h5a}, '{1'h1, 1'h0, 8'h3c, 1'h1, 8'hc3},
                             '{1'h1, 1'h1, 8'h81, 1'h0, 8'h18}};

    always #2.5 clk = ~clk;

    // Error outputs stand one cycle; count every pulse
    always @(posedge clk) begin
        if (rx_frame_err === 1'h1) ferr_seen++;
        if (rx_overrun === 1'h1) ovr_seen++;
    end

    hspfc_top i_dut (
        .CLK(clk), .RST(rst), .FLOW_EN(flow_en), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_OVERRUN(rx_overrun),
        .RX_FRAME_ERR(rx_frame_err), .HOST_TX_LINE(tx_line), .HOST_RX_LINE(rx_line),
        .HOST_CLEAR_TO_SEND_N(cts_pin), .HOST_READY_TO_SEND_N(rts_n)
    );

    hspfc_host_model i_host (
        .clk(clk), .dev_tx_line(tx_line), .dev_rts_n(rts_n), .host_rx_line(rx_line), .host_cts_n(cts_pin),
        .flow_en(flow_en), .cts_n_req(cts_n)
    );

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'h1) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic check_reset();
        check(tx_ready === 1'h1 && tx_line === 1'h1 && rts_n === 1'h0 && rx_valid === 1'h0, "reset state");
    endtask : check_reset

    task automatic put_n(input logic [7:0] first, input int n);
        tx_valid <= 1'h1;
        for (int i = 0; i < n; i++) begin
            tx_data <= first + 8'(i);
            @(posedge clk);
        end
        tx_valid <= 1'h0;
    endtask : put_n

    task automatic run_row(input hspfc_row_t r);
        int base;
        base = i_host.got.size();
        flow_en <= r.flow;
        cts_n <= r.cts_n;
        repeat (4) @(posedge clk);
        put_n(r.tx, 1);
        i_host.send(r.rx);
        check(rx_valid === 1'h1 && rx_data === r.rx, "received byte");
        check(rts_n === r.flow, "ready-to-send while holding full");
        check(i_host.got.size() === base + int'(r.sent), "frame count on host line");
        if (r.sent === 1'h1) begin
            check(i_host.got[base] === r.tx, "transmitted byte");
        end
        rx_ready <= 1'h1;
        @(posedge clk);
        rx_ready <= 1'h0;
        @(negedge clk);
        check(rx_valid === 1'h0 && rts_n === 1'h0, "holding register not released");
        @(posedge clk);
    endtask : run_row

    initial begin : main
        int base;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        check_reset();
        @(posedge clk);
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        // Blocked byte plus 15 fills the buffer; one more is refused
        base = i_host.got.size();
        // Host sends a good byte, then a frame with a low stop bit while the holding register is full
        fork
            begin
                i_host.send(8'h66);
                i_host.send_raw({1'h0, 8'h99, 1'h0});
            end
        join_none
        put_n(8'h10, 15);
        @(negedge clk);
        check(tx_ready === 1'h0, "buffer accepts a 17th byte");
        @(posedge clk);
        put_n(8'hee, 1);
        @(negedge clk);
        check(tx_ready === 1'h0, "buffer still full after refused byte");
        @(posedge clk);
        cts_n <= 1'h0;
        for (int k = 0; k < 20 && tx_line === 1'h1; k++) @(posedge clk);
        repeat (3 * BIT) @(posedge clk);
        cts_n <= 1'h1;
        for (int k = 0; k < 8 * BIT && i_host.got.size() < base + 1; k++) @(posedge clk);
        repeat (2 * BIT) @(posedge clk);
        @(negedge clk);
        check(i_host.got.size() === base + 1 && i_host.got[base] === 8'h81, "frame cut short");
        check(tx_line === 1'h1, "new frame with clear-to-send high");
        $display("pause test done");
        wait fork;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(rx_valid === 1'h1 && rx_data === 8'h66, "bad frame disturbed held byte");
        check(ferr_seen == 1, "frame error pulse count");
        check(ovr_seen == 0, "unexpected overrun pulse");
        $display("receive error test done");
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        check_reset();
        $display("reset test done");
        end_of_test();
    end

    initial begin : watchdog
        repeat (97000) @(posedge clk);
        mismatches++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule : tb_host_serial_port_flow_control
